// file: design/wos_pkg.sv
// Shared constants for the waveform output sequencer
package wos_pkg;

	// ======================================================================
	// Bus geometry
	localparam int WB_AW = 8;
	localparam int WB_DW = 32;
	localparam int SMP_W = 16;

	// ======================================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CFG    = 8'h04;
	localparam logic [7:0] OFS_DIV    = 8'h08;
	localparam logic [7:0] OFS_DELAY  = 8'h0c;
	localparam logic [7:0] OFS_COUNT  = 8'h10;
	localparam logic [7:0] OFS_FIFO   = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_DONE   = 8'h1c;

	// ======================================================================
	// Command bits (write-only, self clearing)
	localparam int CTL_START  = 0;
	localparam int CTL_STOP   = 1;
	localparam int CTL_UPDATE = 2;
	localparam int CTL_FLUSH  = 3;

	// ======================================================================
	// Configuration fields
	localparam int CFG_HW_TIMED   = 0;
	localparam int CFG_BUFFERED   = 1;
	localparam int CFG_CONT       = 2;
	localparam int CFG_REGEN_LO   = 3;
	localparam int CFG_TRIG_EN    = 5;
	localparam int CFG_STRT_ANA   = 6;
	localparam int CFG_STRT_FALL  = 7;
	localparam int CFG_STRT_SEL   = 8;
	localparam int CFG_PAUSE_EN   = 11;
	localparam int CFG_PAUSE_ANA  = 12;
	localparam int CFG_PAUSE_HIGH = 13;
	localparam int CFG_PAUSE_SEL  = 14;
	localparam int CFG_PIN_OUT    = 17;
	localparam int CFG_EXT_UPD    = 18;
	localparam int CFG_EXT_FALL   = 19;
	localparam int CFG_BIP_LO     = 20;
	localparam int CFG_RGL_LO     = 22;
	localparam int CFG_TB_EXT     = 24;
	localparam int CFG_W          = 25;

	localparam logic [1:0] REGEN_HOST = 2'h0;
	localparam logic [1:0] REGEN_FIFO = 2'h1;
	localparam logic [1:0] REGEN_NONE = 2'h2;
	localparam logic [2:0] SEL_INTERNAL = 3'h7;

	// ======================================================================
	// Status fields
	localparam int ST_RUN     = 0;
	localparam int ST_UNDER   = 1;
	localparam int ST_FULL    = 2;
	localparam int ST_EMPTY   = 3;
	localparam int ST_REFUSED = 4;
	localparam int ST_ARMED   = 5;
	localparam int ST_LVL_LO  = 16;

	// ======================================================================
	// Reset values
	localparam logic [CFG_W-1:0] CFG_RST   = 25'h0000000;
	localparam logic [15:0]      DIV_RST   = 16'h0002;
	localparam logic [15:0]      DELAY_RST = 16'h0002;
	localparam logic [31:0]      COUNT_RST = 32'h00000000;

	// ======================================================================
	// Synchroniser slots: lines 0..5, start pin (line 6), timebase,
	// external update clock, analog comparison event
	localparam int SYN_PIN = 6;
	localparam int SYN_TB  = 7;
	localparam int SYN_EXT = 8;
	localparam int SYN_ANA = 9;
	localparam int SYN_N   = 10;

	typedef enum logic [1:0] {
		WOS_IDLE,
		WOS_ARMED,
		WOS_DELAY,
		WOS_RUN
	} wos_state_e;

endpackage : wos_pkg

// file: design/wos_sequencer.sv
// Two-channel waveform output sequencer with Wishbone register slave
// Notes on behaviour
// - Each channel has its own unipolar or bipolar range select bit.
// - Bipolar channel codes are two's complement.
// - Unipolar channel codes are unsigned straight binary.
// - Glitch uniforming starts disabled; one enable bit per channel.
// - Software timing: one update per software update command.
// - Hardware timing: updates paced by internal divider or external clock.
// - Host fills the FIFO; one sample leaves per update.
// - Finite mode stops itself after the programmed sample count when hardware timed and buffered.
// - Continuous mode runs until software stops it.
// - Standard regeneration: host keeps refilling the FIFO.
// - FIFO regeneration loops stored samples and refuses new writes once armed or running.
// - No regeneration: no repeats, underflow flagged on empty FIFO.
// - Non-buffered writes go to the FIFO, out on next update.
// - Start on trigger when enabled, else on software start.
// - Digital start: line 0..6 or internal source, selectable edge.
// - Analog start: first rising edge of comparison event.
// - Start pin as output shows start as a high pulse.
// - Start pin is an input after reset.
// - Pause blocks new samples only at sample boundaries.
// - Digital pause: selectable source and active level.
// - Analog pause when comparison event high; pause never output.
// - One update event refreshes both channels together.
// - Delay start to first internal update, default two ticks.
`timescale 1ns/100ps
module wos_sequencer #(
	parameter int FIFO_DEPTH = 64
) (
	input  wire logic                        clk_sys,
	input  wire logic                        rst_b,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [wos_pkg::WB_AW-1:0]   wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [wos_pkg::WB_DW-1:0]   wb_dat_i,
	output logic      [wos_pkg::WB_DW-1:0]   wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic [5:0]                  programmable_function_line,
	input  wire logic                        start_trigger_pin_i,
	output logic                             start_trigger_pin_o,
	output logic                             start_trigger_pin_oe,
	input  wire logic                        internal_trigger,
	input  wire logic                        internal_pause,
	input  wire logic                        analog_cmp_event,
	input  wire logic                        ext_update_clock,
	input  wire logic                        update_timebase,
	output logic      [wos_pkg::SMP_W-1:0]   dac0_code,
	output logic      [wos_pkg::SMP_W-1:0]   dac1_code,
	output logic                             dac_update,
	output logic      [1:0]                  range_bipolar,
	output logic      [1:0]                  reglitch_en,
	output logic                             underflow_flag
);
	import wos_pkg::*;

	localparam int AW = $clog2(FIFO_DEPTH);

	// Level field of STATUS has room for at most 15 level bits
	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 16384 ||
			(1 << AW) != FIFO_DEPTH) begin : g_bad_depth
		$error("wos_sequencer: FIFO_DEPTH must be a power of two, 2..16384");
	end

	// ======================================================================
	// Declarations
	logic [CFG_W-1:0]   cfg_reg;
	logic [15:0]        div_reg;
	logic [15:0]        delay_reg;
	logic [31:0]        count_reg;
	logic [31:0]        done_reg;
	logic [15:0]        div_cnt_reg;
	logic [15:0]        delay_cnt_reg;
	logic               refused_reg;
	logic               start_prev_reg;
	logic [SYN_N-1:0]   syn_lvl;
	logic [SYN_N-1:0]   syn_prev_reg;
	logic [WB_DW-1:0]   mem [FIFO_DEPTH];
	logic [AW-1:0]      wr_ptr_reg;
	logic [AW-1:0]      rd_ptr_reg;
	logic [AW-1:0]      rg_off_reg;
	logic [AW:0]        level_reg;
	wos_state_e         state_reg;
	logic               bus_take;
	logic               wr_take;
	logic               ctl_wr;
	logic               start_cmd;
	logic               stop_cmd;
	logic               sw_upd_cmd;
	logic               flush_cmd;
	logic               fifo_wr;
	logic               st_wr;
	logic               hw_timed;
	logic               buffered;
	logic               ext_upd;
	logic               regen_loop;
	logic               locked;
	logic               full;
	logic               empty;
	logic               push;
	logic               pop;
	logic               tick;
	logic               ext_edge;
	logic               start_raw;
	logic               start_edge;
	logic               start_go;
	logic               pause_raw;
	logic               pause_active;
	logic               delay_hit;
	logic               div_hit;
	logic               running;
	logic               hw_evt;
	logic               upd_evt;
	logic               upd_fire;
	logic               under_set;
	logic               finish;
	logic [2:0]         strt_sel;
	logic [2:0]         pause_sel;
	logic [15:0]        div_last;
	logic [WB_DW-1:0]   head;
	logic [WB_DW-1:0]   rdata;
	logic [WB_DW-1:0]   status;

	function automatic logic [WB_DW-1:0] merge(input logic [WB_DW-1:0] old,
			input logic [WB_DW-1:0] val, input logic [3:0] sel);
		logic [WB_DW-1:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = val[8*i +: 8];
			end
		end
		return res;
	endfunction : merge

	// Two's complement to offset binary; unsigned as is
	function automatic logic [SMP_W-1:0] to_dac(input logic [SMP_W-1:0] d,
			input logic bip);
		return bip ? {~d[SMP_W-1], d[SMP_W-2:0]} : d;
	endfunction : to_dac

	// ======================================================================
	// Input synchronisers
	wos_sync #(.W(SYN_N)) u_sync (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.async_in  ({analog_cmp_event, ext_update_clock, update_timebase,
			start_trigger_pin_i, programmable_function_line}),
		.level_out (syn_lvl)
	);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			syn_prev_reg   <= '0;
			start_prev_reg <= 1'b0;
		end else begin
			syn_prev_reg   <= syn_lvl;
			start_prev_reg <= start_raw;
		end
	end

	// ======================================================================
	// Wishbone slave: ack one cycle after the request, writes at ack edge
	assign bus_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_take  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign ctl_wr   = wr_take && wb_adr_i == OFS_CTRL && wb_sel_i[0];
	assign start_cmd  = ctl_wr && wb_dat_i[CTL_START];
	assign stop_cmd   = ctl_wr && wb_dat_i[CTL_STOP];
	assign sw_upd_cmd = ctl_wr && wb_dat_i[CTL_UPDATE];
	assign flush_cmd  = ctl_wr && wb_dat_i[CTL_FLUSH];
	assign fifo_wr  = wr_take && wb_adr_i == OFS_FIFO;
	assign st_wr    = wr_take && wb_adr_i == OFS_STATUS && wb_sel_i[0];

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= bus_take;
			if (bus_take) begin
				wb_dat_o <= rdata;
			end
		end
	end

	// Configuration comes up with glitch uniforming off
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cfg_reg   <= CFG_RST;
			div_reg   <= DIV_RST;
			delay_reg <= DELAY_RST;
			count_reg <= COUNT_RST;
		end else if (wr_take) begin
			unique case (wb_adr_i)
				OFS_CFG: cfg_reg <= CFG_W'(merge(32'(cfg_reg), wb_dat_i,
						wb_sel_i));
				OFS_DIV: div_reg <= 16'(merge(32'(div_reg), wb_dat_i,
						wb_sel_i));
				OFS_DELAY: delay_reg <= 16'(merge(32'(delay_reg), wb_dat_i,
						wb_sel_i));
				OFS_COUNT: count_reg <= merge(count_reg, wb_dat_i, wb_sel_i);
				default: begin
				end
			endcase
		end
	end

	assign status = {{(16 - AW - 1){1'b0}}, level_reg, 10'h000,
		state_reg == WOS_ARMED, refused_reg, empty, full, underflow_flag,
		running};

	always_comb begin
		unique case (wb_adr_i)
			OFS_CFG:    rdata = 32'(cfg_reg);
			OFS_DIV:    rdata = 32'(div_reg);
			OFS_DELAY:  rdata = 32'(delay_reg);
			OFS_COUNT:  rdata = count_reg;
			OFS_STATUS: rdata = status;
			OFS_DONE:   rdata = done_reg;
			default:    rdata = 32'h00000000;
		endcase
	end

	// ======================================================================
	// Configuration decode
	assign hw_timed   = cfg_reg[CFG_HW_TIMED];
	assign buffered   = cfg_reg[CFG_BUFFERED];
	assign ext_upd    = cfg_reg[CFG_EXT_UPD];
	assign strt_sel   = cfg_reg[CFG_STRT_SEL +: 3];
	assign pause_sel  = cfg_reg[CFG_PAUSE_SEL +: 3];
	// Range and reglitch bits, one per channel
	assign range_bipolar = cfg_reg[CFG_BIP_LO +: 2];
	assign reglitch_en   = cfg_reg[CFG_RGL_LO +: 2];
	// Pin output enable resets low, so the pin starts as input
	assign start_trigger_pin_oe = cfg_reg[CFG_PIN_OUT];

	// ======================================================================
	// Trigger selection
	// Source lines 0..6 or internal signal, chosen edge
	assign start_raw = cfg_reg[CFG_STRT_ANA] ? syn_lvl[SYN_ANA] :
		(strt_sel == SEL_INTERNAL) ? internal_trigger : syn_lvl[strt_sel];
	// Analog source always starts on the rising edge
	assign start_edge = (cfg_reg[CFG_STRT_FALL] && !cfg_reg[CFG_STRT_ANA]) ?
		(start_prev_reg && !start_raw) : (!start_prev_reg && start_raw);

	// Digital pause source and level; analog high pauses
	assign pause_raw = cfg_reg[CFG_PAUSE_ANA] ? syn_lvl[SYN_ANA] :
		(pause_sel == SEL_INTERNAL) ? internal_pause : syn_lvl[pause_sel];
	assign pause_active = cfg_reg[CFG_PAUSE_EN] &&
		(cfg_reg[CFG_PAUSE_ANA] || cfg_reg[CFG_PAUSE_HIGH] ?
		pause_raw : !pause_raw);

	// Trigger when enabled, otherwise the software command
	assign start_go = (state_reg == WOS_IDLE && start_cmd &&
		!cfg_reg[CFG_TRIG_EN]) || (state_reg == WOS_ARMED && start_edge);

	// ======================================================================
	// Update pacing
	assign tick = cfg_reg[CFG_TB_EXT] ?
		(syn_lvl[SYN_TB] && !syn_prev_reg[SYN_TB]) : 1'b1;
	assign ext_edge = cfg_reg[CFG_EXT_FALL] ?
		(syn_prev_reg[SYN_EXT] && !syn_lvl[SYN_EXT]) :
		(!syn_prev_reg[SYN_EXT] && syn_lvl[SYN_EXT]);
	assign div_last  = (div_reg == 16'h0000) ? 16'h0000 : div_reg - 16'h0001;
	assign div_hit   = tick && div_cnt_reg >= div_last;
	// Delay counted in timebase ticks from the start
	assign delay_hit = delay_reg == 16'h0000 ||
		(tick && delay_cnt_reg >= delay_reg - 16'h0001);
	assign running = state_reg == WOS_DELAY || state_reg == WOS_RUN;

	// Internal divider or external clock; pause gates
	// every sample boundary for as long as it is active
	assign hw_evt = hw_timed && !pause_active &&
		((state_reg == WOS_RUN && (ext_upd ? ext_edge : div_hit)) ||
		(state_reg == WOS_DELAY && delay_hit));
	assign upd_evt  = hw_timed ? hw_evt : sw_upd_cmd;
	assign upd_fire = upd_evt && !empty;
	assign under_set = hw_evt && buffered && !regen_loop && empty;
	assign finish = running && hw_timed && buffered &&
		!cfg_reg[CFG_CONT] && upd_fire && done_reg + 32'h1 == count_reg;

	// ======================================================================
	// Sequence state
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= WOS_IDLE;
		end else if (stop_cmd) begin
			state_reg <= WOS_IDLE;
		end else begin
			unique case (state_reg)
				WOS_IDLE: begin
					if (start_go) begin
						state_reg <= ext_upd ? WOS_RUN : WOS_DELAY;
					end else if (start_cmd) begin
						state_reg <= WOS_ARMED;
					end
				end
				WOS_ARMED: begin
					if (start_go) begin
						state_reg <= ext_upd ? WOS_RUN : WOS_DELAY;
					end
				end
				WOS_DELAY: begin
					if (finish) begin
						state_reg <= WOS_IDLE;
					end else if (delay_hit) begin
						state_reg <= WOS_RUN;
					end
				end
				WOS_RUN: begin
					// Continuous run leaves only on stop
					if (finish) begin
						state_reg <= WOS_IDLE;
					end
				end
			endcase
		end
	end

	// Divider holds its count while paused
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt_reg   <= 16'h0000;
			delay_cnt_reg <= 16'h0000;
		end else if (start_go || state_reg == WOS_DELAY) begin
			div_cnt_reg   <= 16'h0000;
			delay_cnt_reg <= (start_go || !tick) ? (start_go ? 16'h0000 :
				delay_cnt_reg) : delay_cnt_reg + 16'h0001;
		end else if (state_reg == WOS_RUN && !pause_active && tick) begin
			div_cnt_reg <= div_hit ? 16'h0000 : div_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			done_reg <= 32'h00000000;
		end else if (start_go) begin
			done_reg <= 32'h00000000;
		end else if (upd_fire) begin
			done_reg <= done_reg + 32'h1;
		end
	end

	// Start shown on the pin as a one-cycle high pulse
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			start_trigger_pin_o <= 1'b0;
		end else begin
			start_trigger_pin_o <= start_go;
		end
	end

	// ======================================================================
	// Sample FIFO
	// Looping from the FIFO locks out writes once out of idle (armed or running)
	assign regen_loop = hw_timed && buffered &&
		cfg_reg[CFG_REGEN_LO +: 2] == REGEN_FIFO;
	assign locked = regen_loop && state_reg != WOS_IDLE;
	assign full   = level_reg == (AW + 1)'(FIFO_DEPTH);
	assign empty  = level_reg == '0;
	// Host writes land in the FIFO
	assign push   = fifo_wr && !full && !locked;
	assign pop    = upd_fire && !regen_loop;
	assign head   = mem[rd_ptr_reg + (regen_loop ? rg_off_reg : '0)];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr_reg] <= wb_dat_i;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			level_reg  <= '0;
		end else if (flush_cmd && state_reg == WOS_IDLE) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			level_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			level_reg  <= level_reg + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

	// Loop offset wraps over the whole stored buffer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rg_off_reg <= '0;
		end else if (start_go || !regen_loop) begin
			rg_off_reg <= '0;
		end else if (upd_fire) begin
			rg_off_reg <= ({1'b0, rg_off_reg} == level_reg - 1'b1) ? '0 :
				rg_off_reg + 1'b1;
		end
	end

	// Sticky flags: a new event beats a clear
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			underflow_flag <= 1'b0;
			refused_reg    <= 1'b0;
		end else begin
			underflow_flag <= under_set ||
				(underflow_flag && !(st_wr && wb_dat_i[ST_UNDER]));
			refused_reg <= (fifo_wr && (full || locked)) ||
				(refused_reg && !(st_wr && wb_dat_i[ST_REFUSED]));
		end
	end

	// ======================================================================
	// Converter outputs
	// Both channels load on the same update
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			dac0_code  <= '0;
			dac1_code  <= '0;
			dac_update <= 1'b0;
		end else begin
			dac_update <= upd_fire;
			if (upd_fire) begin
				dac0_code <= to_dac(head[SMP_W-1:0], range_bipolar[0]);
				dac1_code <= to_dac(head[2*SMP_W-1:SMP_W], range_bipolar[1]);
			end
		end
	end

	// ======================================================================
	// Assertions
	a_ack_single: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wb_ack_o |=> !wb_ack_o) else $error("ack held over one cycle");
	a_sw_update: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!hw_timed && sw_upd_cmd && !empty) |=> dac_update ##1 !dac_update)
		else $error("software update did not give one update");
	a_pause_blocks: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(hw_timed && pause_active) |=> !dac_update)
		else $error("update while paused");
	a_finite_stop: assert property (@(posedge clk_sys) disable iff (!rst_b)
		finish && !stop_cmd |=> state_reg == WOS_IDLE ##1 !dac_update)
		else $error("finite run did not stop");
	a_cont_runs: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state_reg == WOS_RUN && cfg_reg[CFG_CONT] && !stop_cmd)
		|=> state_reg == WOS_RUN) else $error("continuous run ended");
	a_under_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
		under_set |=> underflow_flag ##1 (underflow_flag || $past(st_wr)))
		else $error("underflow not latched");
	a_under_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(underflow_flag && !st_wr) |=> underflow_flag)
		else $error("underflow flag lost");
	a_start_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
		start_go |=> start_trigger_pin_o ##1 !start_trigger_pin_o)
		else $error("start pulse wrong");
	a_regen_lock: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(locked && fifo_wr) |=> $stable(wr_ptr_reg) && refused_reg)
		else $error("write accepted while looping");
	a_both_chan: assert property (@(posedge clk_sys) disable iff (!rst_b)
		($changed(dac0_code) || $changed(dac1_code)) |-> dac_update)
		else $error("channel changed outside an update");
	c_finite_done: cover property (@(posedge clk_sys) disable iff (!rst_b)
		finish);
	c_underflow: cover property (@(posedge clk_sys) disable iff (!rst_b)
		under_set);
	c_regen_wrap: cover property (@(posedge clk_sys) disable iff (!rst_b)
		regen_loop && upd_fire && rg_off_reg != '0 ##1 rg_off_reg == '0);
	c_pause_run: cover property (@(posedge clk_sys) disable iff (!rst_b)
		state_reg == WOS_RUN && pause_active ##1 !pause_active);

endmodule : wos_sequencer

// file: design/wos_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module wos_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] level_out
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	if (W < 1) begin : g_bad_width
		$error("wos_sync: W must be at least 1");
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s1_reg    <= '0;
			s2_reg    <= '0;
			s3_reg    <= '0;
			level_out <= '0;
		end else begin
			s1_reg    <= async_in;
			s2_reg    <= s1_reg;
			s3_reg    <= s2_reg;
			// Only a value seen twice in a row is believed
			level_out <= (s2_reg & s3_reg) | (level_out & (s2_reg ^ s3_reg));
		end
	end

endmodule : wos_sync

// file: tb/tb_wos_sequencer.sv
// Self-checking bench for the waveform output sequencer
`timescale 1ns/100ps
module tb_wos_sequencer;
	import wos_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        cyc, stb, we, ack, upd, oe, uf, po;
	logic        itrig = 1'b0;
	logic        ipause = 1'b0;
	logic [3:0]  sel;
	logic [7:0]  adr;
	logic [31:0] dw, dr, q;
	logic [15:0] c0, c1;
	logic [1:0]  bip, rgl;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          n_upd = 0;
	int          n0;
	int          n_po = 0;
	initial forever #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (upd === 1'b1)
			n_upd++;
		if (po === 1'b1)
			n_po++;
	end
	wos_host wos_host_inst (.clk_sys(clk_sys), .wb_cyc(cyc), .wb_stb(stb),
		.wb_we(we), .wb_sel(sel), .wb_adr(adr), .wb_dat(dw), .wb_dat_i(dr),
		.wb_ack_i(ack));
	wos_sequencer wos_sequencer_inst (.clk_sys(clk_sys), .rst_b(rst_b),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
		.programmable_function_line(6'h00), .start_trigger_pin_i(1'b0),
		.start_trigger_pin_o(po), .start_trigger_pin_oe(oe),
		.internal_trigger(itrig), .internal_pause(ipause),
		.analog_cmp_event(1'b0), .ext_update_clock(1'b0),
		.update_timebase(1'b0), .dac0_code(c0), .dac1_code(c1),
		.dac_update(upd), .range_bipolar(bip), .reglitch_en(rgl),
		.underflow_flag(uf));
	// ======================================================================
	// Shared tasks
	task automatic check(input string nm, input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wos_host_inst.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		wos_host_inst.xfer(1'b0, a, 32'h0, q);
	endtask : rd
	// Values read at an edge are those launched by the edge before
	task automatic wait_upd;
		int i;
		@(posedge clk_sys);
		for (i = 0; i < 50 && upd !== 1'b1; i++)
			@(posedge clk_sys);
		check("upd_wait", {31'h0, upd}, 32'h1);
	endtask : wait_upd
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	// ======================================================================
	// Scenarios
	task automatic t_reset;
		rd(OFS_CFG);
		check("cfg", q, 32'h0);
		check("pin_oe", {31'h0, oe}, 32'h0);
		rd(OFS_DELAY);
		check("delay", q, 32'h2);
		rd(8'h30);
		check("unmapped", q, 32'h0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_sw;
		wr(OFS_CFG, 32'h0090_0000);
		check("bipolar", {30'h0, bip}, 32'h1);
		check("reglitch", {30'h0, rgl}, 32'h2);
		n0 = n_upd;
		wr(OFS_FIFO, 32'h8000_1234);
		wr(OFS_CTRL, 32'h4);
		wr(OFS_CTRL, 32'h4);
		check("updates", n_upd - n0, 32'h1);
		// Bipolar code leaves as offset binary
		check("dac0", {16'h0, c0}, 32'h9234);
		check("dac1", {16'h0, c1}, 32'h8000);
		$display("software timed test done");
	endtask : t_sw
	task automatic t_finite;
		int i;
		// Host regeneration: the host keeps the FIFO supplied
		wr(OFS_CFG, 32'h03);
		wr(OFS_COUNT, 32'h3);
		for (i = 0; i < 3; i++)
			wr(OFS_FIFO, 32'h0001_0001 * i);
		n0 = n_upd;
		wr(OFS_CTRL, 32'h1);
		q = 32'h1;
		for (i = 0; i < 40 && q[ST_RUN]; i++)
			rd(OFS_STATUS);
		check("stopped", {31'h0, q[ST_RUN]}, 32'h0);
		check("updates", n_upd - n0, 32'h3);
		rd(OFS_DONE);
		check("done", q, 32'h3);
		$display("finite test done");
	endtask : t_finite
	task automatic t_under;
		wr(OFS_CFG, 32'h17);
		wr(OFS_FIFO, 32'h0);
		n0 = n_upd;
		wr(OFS_CTRL, 32'h1);
		repeat (30) @(posedge clk_sys);
		rd(OFS_STATUS);
		check("running", {31'h0, q[ST_RUN]}, 32'h1);
		check("underflow", {31'h0, uf}, 32'h1);
		check("no repeat", n_upd - n0, 32'h1);
		wr(OFS_CTRL, 32'h2);
		check("sticky", {31'h0, uf}, 32'h1);
		wr(OFS_STATUS, 32'h2);
		check("cleared", {31'h0, uf}, 32'h0);
		$display("underflow test done");
	endtask : t_under
	// FIFO loop, internal start trigger, pin output and internal pause
	task automatic t_regen;
		int i;
		int m;
		wr(OFS_CFG, 32'h0003_ef2f);
		wr(OFS_FIFO, 32'h0011_0010);
		wr(OFS_FIFO, 32'h0021_0020);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_FIFO, 32'h0031_0030);
		rd(OFS_STATUS);
		check("armed", {31'h0, q[ST_ARMED]}, 32'h1);
		check("refused", {31'h0, q[ST_REFUSED]}, 32'h1);
		check("level", {16'h0, q[31:16]}, 32'h2);
		check("pin_oe", {31'h0, oe}, 32'h1);
		n0 = n_po;
		itrig <= 1'b1;
		repeat (3) @(posedge clk_sys);
		itrig <= 1'b0;
		for (i = 0; i < 5; i++) begin
			wait_upd;
			check("loop", {c1, c0}, i[0] ? 32'h0021_0020 : 32'h0011_0010);
		end
		ipause <= 1'b1;
		@(posedge clk_sys);
		m = n_upd;
		repeat (20) @(posedge clk_sys);
		check("paused", n_upd - m, 32'h0);
		ipause <= 1'b0;
		wait_upd;
		check("resume", {c1, c0}, 32'h0021_0020);
		wr(OFS_CTRL, 32'h2);
		check("pin pulse", n_po - n0, 32'h1);
		$display("regeneration test done");
	endtask : t_regen
	initial begin
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (5) @(posedge clk_sys);
		t_reset;
		t_sw;
		t_finite;
		t_under;
		t_regen;
		check("timeouts", wos_host_inst.n_to, 32'h0);
		print_verdict;
	end
endmodule : tb_wos_sequencer

// file: tb/wos_host.sv
// Host model: Wishbone master that fills the sample FIFO
`timescale 1ns/100ps
module wos_host (
	input  wire logic        clk_sys,
	output logic             wb_cyc,
	output logic             wb_stb,
	output logic             wb_we,
	output logic [3:0]       wb_sel,
	output logic [7:0]       wb_adr,
	output logic [31:0]      wb_dat,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        wb_ack_i
);
	int n_to = 0;
	initial begin
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_sel = 4'h0;
		wb_adr = 8'h00;
		wb_dat = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int i;
		i = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_sel <= 4'hf;
		wb_we <= w;
		wb_adr <= a;
		wb_dat <= d;
		@(posedge clk_sys);
		while (wb_ack_i !== 1'b1 && i < 20) begin
			@(posedge clk_sys);
			i++;
		end
		if (i == 20)
			n_to++;
		q = wb_dat_i;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_sys);
	endtask : xfer
endmodule : wos_host
